// *** bench/ecc_regs_bench.sv ***
// Self-checking bench for the echo canceller control register slice.
// Assumes the package, the design and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ecc_consts.svh"
module ecc_regs_bench;
    import ecc_pkg::*;
    typedef struct packed {logic [7:0] a, d, e;} ecc_row_t;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, rx_m = 1'b0, tx_m = 1'b0;
    logic [15:0] rx_s = 16'h0000, tx_s = 16'h0000;
    ecc_bus_req_t req = '0;
    ecc_detect_t det = '0;
    wire logic [15:0] rx_o, tx_o;
    wire logic [7:0] rdata;
    wire logic rvalid, nb_any;
    wire ecc_corner_t rx_c, tx_c;
    wire logic [5:0] step;
    int errors = 0, checks = 0;
    ecc_row_t rows [6] = '{'{8'h03, 8'h15, 8'h15}, '{8'h05, 8'h3f, 8'h3f},
        '{8'h07, 8'h5a, 8'h5a}, '{8'h02, 8'h23, 8'h00},
        '{8'h06, 8'hff, 8'h00}, '{8'h00, 8'h12, 8'h00}};
    ecc_corner_t rx_tab [8] = '{20'h30d40, 20'h14050, 20'h088b8, 20'h03e80,
        20'h01f40, 20'h00fa0, 20'h007d0, 20'h003e8};
    logic [7:0] tx_k [5] = '{8'h00, 8'h07, 8'h08, 8'h18, 8'h1f};
    ecc_corner_t tx_v [5] = '{20'h30d40, 20'h003e8, 20'h00109, 20'h00168,
        20'h00708};
    logic [7:0] rs_a [5] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h07};
    logic [7:0] rs_v [5] = '{8'h00, 8'h60, 8'ha1, 8'h08, 8'hff};
    always #25 clk = ~clk;
    ecc_regs #(.SAMPLE_W(16)) DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
        .I_REQ(req), .O_RDATA(rdata), .O_RVALID(rvalid), .I_DET(det),
        .I_RX_MUTE(rx_m), .I_TX_MUTE(tx_m), .I_RX_SAMPLE(rx_s),
        .I_TX_SAMPLE(tx_s), .O_RX_OUT(rx_o), .O_TX_OUT(tx_o),
        .O_RX_CORNER(rx_c), .O_TX_CORNER(tx_c), .O_STEP_SIZE(step),
        .O_NB_ANY(nb_any));
    task automatic fail(input string m);
        errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk_b(input logic [7:0] g, e);
        checks++;
        if (g !== e) fail($sformatf("byte %h want %h", g, e));
    endtask
    task automatic chk_c(input ecc_corner_t g, e);
        checks++;
        if (g !== e) fail($sformatf("corner %h want %h", g, e));
    endtask
    task automatic chk_s(input logic [15:0] g, e);
        checks++;
        if (g !== e) fail($sformatf("sample %h want %h", g, e));
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req.rd <= 1'b0;
        #1 chk_b({7'h00, rvalid}, 8'h01);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        errors++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        settle;
        chk_b({2'b00, step}, 8'h08);
        chk_c(rx_c, 20'h00fa0);
        chk_c(tx_c, 20'h14050);
        foreach (rs_a[i]) begin
            rd(rs_a[i]);
            chk_b(rdata, rs_v[i]);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk_b(rdata, rows[i].e);
        end
        chk_b({2'b00, step}, 8'h3f);
        for (int c = 0; c < 8; c++) begin
            wr(8'h04, {c[2:0], 5'h1c});
            settle;
            chk_c(rx_c, rx_tab[c]);
            chk_c(tx_c, 20'h03a98);
        end
        foreach (tx_k[i]) begin
            wr(8'h04, tx_k[i]);
            settle;
            chk_c(tx_c, tx_v[i]);
            chk_c(rx_c, 20'h30d40);
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) det <= i[2:0];
            rd(8'h02);
            chk_b(rdata, {2'b00, i[0], 3'b000, i[2] | i[1], i[2]});
            chk_b({7'h00, nb_any}, {7'h00, i[2] | i[1]});
        end
        @(posedge clk) rx_s <= 16'h1234;
        tx_s <= 16'hbeef;
        rx_m <= 1'b1;
        settle;
        chk_s(rx_o, 16'h0015);
        chk_s(tx_o, 16'hbeef);
        @(posedge clk) rx_m <= 1'b0;
        tx_m <= 1'b1;
        settle;
        chk_s(rx_o, 16'h1234);
        chk_s(tx_o, 16'h0015);
        @(posedge clk) ce <= 1'b0;
        det <= 3'b000;
        wr(8'h05, 8'h01);
        ce <= 1'b1;
        #1 chk_b({7'h00, nb_any}, 8'h01);
        rd(8'h05);
        chk_b(rdata, 8'h3f);
        @(posedge clk) rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        settle;
        chk_b({2'b00, step}, 8'h08);
        rd(8'h03);
        chk_b(rdata, 8'h60);
        report_and_stop;
    end
endmodule // ecc_regs_bench
`default_nettype wire

// *** bench/ecc_regs_monitor.sv ***
// Assertion checker for the echo canceller control register slice.
// Assumes it is bound to ecc_regs and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "ecc_consts.svh"
module ecc_regs_monitor #(parameter int SAMPLE_W = 16) (
    input wire logic I_CLK, I_RST_N, I_CE, I_RX_MUTE, I_TX_MUTE,
    input wire ecc_pkg::ecc_bus_req_t I_REQ,
    input wire ecc_pkg::ecc_detect_t I_DET,
    input wire logic [SAMPLE_W-1:0] I_RX_SAMPLE, I_TX_SAMPLE,
    input wire logic [SAMPLE_W-1:0] O_RX_OUT, O_TX_OUT,
    input wire logic [`ECC_DATA_W-1:0] O_RDATA,
    input wire logic O_RVALID, O_NB_ANY,
    input wire ecc_pkg::ecc_corner_t O_RX_CORNER, O_TX_CORNER,
    input wire logic [`ECC_STEP_HI:0] O_STEP_SIZE
);
    import ecc_pkg::*;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    wire logic rd_ok = I_CE && I_REQ.rd;
    wire logic wr_ok = I_CE && I_REQ.wr;
    wire logic wr_step = wr_ok && I_REQ.addr == `ECC_OFF_STEP;
    wire logic wr_hpf = wr_ok && I_REQ.addr == `ECC_OFF_HPF;
    wire logic mapped = I_REQ.addr inside {8'h02, 8'h03, 8'h04, 8'h05, 8'h07};
    sequence s_rd_status;
        rd_ok && I_REQ.addr == `ECC_OFF_STATUS && $past(I_CE) && $past(I_RST_N);
    endsequence
    sequence s_step_wr;
        wr_step ##1 I_CE;
    endsequence
    property p_rd_status;
        s_rd_status |=> O_RDATA == {2'b00, $past(I_DET.false_howl, 2), 3'b000,
            $past(I_DET.nb_rx | I_DET.nb_tx, 2), $past(I_DET.nb_rx, 2)};
    endproperty
    property p_nb_any;
        $past(I_CE) && $past(I_CE, 2) && $past(I_RST_N, 2)
            |-> O_NB_ANY == $past(I_DET.nb_rx | I_DET.nb_tx, 2);
    endproperty
    property p_rvalid; rd_ok |=> O_RVALID; endproperty
    property p_no_rvalid; I_CE && !I_REQ.rd |=> !O_RVALID; endproperty
    property p_unmapped; rd_ok && !mapped |=> O_RDATA == `ECC_RDATA_IDLE; endproperty
    property p_rdata_hold; $changed(O_RDATA) |-> $past(rd_ok); endproperty
    property p_rx_pass; I_CE && !I_RX_MUTE |=> O_RX_OUT == $past(I_RX_SAMPLE); endproperty
    property p_tx_pass; I_CE && !I_TX_MUTE |=> O_TX_OUT == $past(I_TX_SAMPLE); endproperty
    property p_step; s_step_wr |=> O_STEP_SIZE == $past(I_REQ.wdata[5:0], 2); endproperty
    property p_ctl_hold;
        ($changed(O_STEP_SIZE) || $changed(O_RX_CORNER) || $changed(O_TX_CORNER))
            && $past(I_RST_N, 2) |-> $past(wr_step || wr_hpf, 2);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");
    a_nb_any: assert property (p_nb_any) else $error("combined flag wrong");
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_no_rvalid: assert property (p_no_rvalid) else $error("stray read valid");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_rx_pass: assert property (p_rx_pass) else $error("receive pass wrong");
    a_tx_pass: assert property (p_tx_pass) else $error("send pass wrong");
    a_step: assert property (p_step) else $error("step size wrong");
    a_ctl_hold: assert property (p_ctl_hold) else $error("control moved");
endmodule // ecc_regs_monitor
bind ecc_regs ecc_regs_monitor #(.SAMPLE_W(SAMPLE_W)) u_mon (.I_CLK(I_CLK),
    .I_RST_N(I_RST_N), .I_CE(I_CE), .I_RX_MUTE(I_RX_MUTE), .I_TX_MUTE(I_TX_MUTE),
    .I_REQ(I_REQ), .I_DET(I_DET), .I_RX_SAMPLE(I_RX_SAMPLE),
    .I_TX_SAMPLE(I_TX_SAMPLE), .O_RX_OUT(O_RX_OUT), .O_TX_OUT(O_TX_OUT),
    .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_NB_ANY(O_NB_ANY),
    .O_RX_CORNER(O_RX_CORNER), .O_TX_CORNER(O_TX_CORNER),
    .O_STEP_SIZE(O_STEP_SIZE));
`default_nettype wire

// *** verilog/ecc_consts.svh ***
// Register offsets, field positions, reset values and widths for the
// echo canceller control register slice.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ECC_CONSTS_SVH
`define ECC_CONSTS_SVH

`define ECC_ADDR_W          8
`define ECC_DATA_W          8
`define ECC_CORNER_W        20
`define ECC_CODE_W          5

`define ECC_OFF_STATUS      8'h02
`define ECC_OFF_MUTE_OFS    8'h03
`define ECC_OFF_HPF         8'h04
`define ECC_OFF_STEP        8'h05
`define ECC_OFF_BOOT_CHK    8'h07

`define ECC_RST_STATUS      8'h00
`define ECC_RST_MUTE_OFS    8'h60
`define ECC_RST_HPF         8'ha1
`define ECC_RST_STEP        8'h08
`define ECC_RST_BOOT_CHK    8'hff
`define ECC_RDATA_IDLE      8'h00

`define ECC_BIT_NB_RX       0
`define ECC_BIT_NB_ANY      1
`define ECC_BIT_FALSE_HOWL  5
`define ECC_MUTE_OFS_HI     4
`define ECC_MUTE_OFS_LO     0
`define ECC_RX_HPF_HI       7
`define ECC_RX_HPF_LO       5
`define ECC_TX_HPF_HI       4
`define ECC_TX_HPF_LO       0
`define ECC_STEP_HI         5
`define ECC_STEP_LO         0

`endif

// *** verilog/ecc_hpf_corner.sv ***
// Maps a high-pass corner code to its 3 dB frequency in units of 0.01 Hz.
// Assumes a caller that registers the result; purely combinational here.
`default_nettype none
`timescale 1ns/100ps
`include "ecc_consts.svh"

module ecc_hpf_corner (
    // Corner code.
    input  wire logic [`ECC_CODE_W-1:0]  i_code,
    // Corner frequency in centihertz.
    output logic      [`ECC_CORNER_W-1:0] o_corner
);

    always_comb begin
        unique case (i_code)
            5'h00: o_corner = 20'h30d40;
            5'h01: o_corner = 20'h14050;
            5'h02: o_corner = 20'h088b8;
            5'h03: o_corner = 20'h03e80;
            5'h04: o_corner = 20'h01f40;
            5'h05: o_corner = 20'h00fa0;
            5'h06: o_corner = 20'h007d0;
            5'h07: o_corner = 20'h003e8;
            5'h08: o_corner = 20'h00109;
            5'h09: o_corner = 20'h1adb0;
            5'h0a: o_corner = 20'h0afc8;
            5'h0b: o_corner = 20'h04e20;
            5'h0c: o_corner = 20'h02710;
            5'h0d: o_corner = 20'h01388;
            5'h0e: o_corner = 20'h009c4;
            5'h0f: o_corner = 20'h00578;
            5'h10: o_corner = 20'h493e0;
            5'h11: o_corner = 20'h1d4c0;
            5'h12: o_corner = 20'h0e290;
            5'h13: o_corner = 20'h061a8;
            5'h14: o_corner = 20'h030d4;
            5'h15: o_corner = 20'h01770;
            5'h16: o_corner = 20'h00bb8;
            5'h17: o_corner = 20'h005dc;
            5'h18: o_corner = 20'h00168;
            5'h19: o_corner = 20'h27100;
            5'h1a: o_corner = 20'h11170;
            5'h1b: o_corner = 20'h07530;
            5'h1c: o_corner = 20'h03a98;
            5'h1d: o_corner = 20'h01b58;
            5'h1e: o_corner = 20'h00ed8;
            5'h1f: o_corner = 20'h00708;
        endcase
    end

endmodule // ecc_hpf_corner

`default_nettype wire

// *** verilog/ecc_pkg.sv ***
// Types shared by the echo canceller control register slice.
// Assumes ecc_consts.svh sits on the include path.
`default_nettype none
`include "ecc_consts.svh"

package ecc_pkg;

    // One register port request, valid for a single clock.
    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [`ECC_ADDR_W-1:0]   addr;
        logic [`ECC_DATA_W-1:0]   wdata;
    } ecc_bus_req_t;

    // Detector results delivered by the canceller datapath.
    typedef struct packed {
        logic nb_rx;
        logic nb_tx;
        logic false_howl;
    } ecc_detect_t;

    typedef logic [`ECC_CORNER_W-1:0] ecc_corner_t;

endpackage

`default_nettype wire

// *** verilog/ecc_regs.sv ***
// Control and status register slice of the hands-free echo canceller.
// Assumes register requests and detector results come from logic on I_CLK.
`default_nettype none
`timescale 1ns/100ps
`include "ecc_consts.svh"

module ecc_regs #(
    parameter int SAMPLE_W = 16
) (
    // Clock, reset and clock enable.
    input  wire logic                     I_CLK,
    input  wire logic                     I_RST_N,
    input  wire logic                     I_CE,
    // Register port.
    input  wire ecc_pkg::ecc_bus_req_t    I_REQ,
    output logic [`ECC_DATA_W-1:0]        O_RDATA,
    output logic                          O_RVALID,
    // Detector results from the datapath.
    input  wire ecc_pkg::ecc_detect_t     I_DET,
    // Sample paths with mute.
    input  wire logic                     I_RX_MUTE,
    input  wire logic                     I_TX_MUTE,
    input  wire logic [SAMPLE_W-1:0]      I_RX_SAMPLE,
    input  wire logic [SAMPLE_W-1:0]      I_TX_SAMPLE,
    output logic [SAMPLE_W-1:0]           O_RX_OUT,
    output logic [SAMPLE_W-1:0]           O_TX_OUT,
    // Filter and adaptation controls, and the combined narrowband flag.
    output ecc_pkg::ecc_corner_t          O_RX_CORNER,
    output ecc_pkg::ecc_corner_t          O_TX_CORNER,
    output logic [`ECC_STEP_HI:0]         O_STEP_SIZE,
    output logic                          O_NB_ANY
);
    import ecc_pkg::*;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [`ECC_DATA_W-1:0] mute_offset_level_ff;
    logic [`ECC_DATA_W-1:0] highpass_corner_select_ff;
    logic [`ECC_DATA_W-1:0] adaptation_step_constant_ff;
    logic [`ECC_DATA_W-1:0] boot_image_check_ff;
    logic                   narrowband_receive_flag_ff;
    logic                   narrowband_send_flag_ff;
    logic                   false_howling_flag_ff;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic hit_status = (I_REQ.addr == `ECC_OFF_STATUS);
    wire logic hit_mute   = (I_REQ.addr == `ECC_OFF_MUTE_OFS);
    wire logic hit_hpf    = (I_REQ.addr == `ECC_OFF_HPF);
    wire logic hit_step   = (I_REQ.addr == `ECC_OFF_STEP);
    wire logic hit_boot   = (I_REQ.addr == `ECC_OFF_BOOT_CHK);

    wire logic wr_mute = I_REQ.wr && hit_mute;
    wire logic wr_hpf  = I_REQ.wr && hit_hpf;
    wire logic wr_step = I_REQ.wr && hit_step;
    wire logic wr_boot = I_REQ.wr && hit_boot;

    // Status bits are hardware owned; reserved bits read as zero, so the
    // zero that software must write there is never stored.
    wire logic narrowband_any_flag =
        narrowband_receive_flag_ff | narrowband_send_flag_ff;

    logic [`ECC_DATA_W-1:0] status_word;
    always_comb begin
        status_word                      = `ECC_RST_STATUS;
        status_word[`ECC_BIT_NB_RX]      = narrowband_receive_flag_ff;
        status_word[`ECC_BIT_NB_ANY]     = narrowband_any_flag;
        status_word[`ECC_BIT_FALSE_HOWL] = false_howling_flag_ff;
    end

    // Unmapped addresses read as the idle value.
    wire logic [`ECC_DATA_W-1:0] nxt_rdata =
        hit_status ? status_word :
        hit_mute   ? mute_offset_level_ff :
        hit_hpf    ? highpass_corner_select_ff :
        hit_step   ? adaptation_step_constant_ff :
        hit_boot   ? boot_image_check_ff : `ECC_RDATA_IDLE;

    // ------------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------------
    wire logic [`ECC_MUTE_OFS_HI:0] mute_offset_value =
        mute_offset_level_ff[`ECC_MUTE_OFS_HI:`ECC_MUTE_OFS_LO];
    wire logic [`ECC_RX_HPF_HI-`ECC_RX_HPF_LO:0] receive_hpf_corner =
        highpass_corner_select_ff[`ECC_RX_HPF_HI:`ECC_RX_HPF_LO];
    wire logic [`ECC_TX_HPF_HI:0] send_hpf_corner =
        highpass_corner_select_ff[`ECC_TX_HPF_HI:`ECC_TX_HPF_LO];
    wire logic [`ECC_STEP_HI:0] adaptation_step_size =
        adaptation_step_constant_ff[`ECC_STEP_HI:`ECC_STEP_LO];

    // Offset zero-extended to the sample width.
    wire logic [SAMPLE_W-1:0] mute_level =
        SAMPLE_W'(mute_offset_value);

    // A muted path carries the programmed offset in place of its sample.
    wire logic [SAMPLE_W-1:0] nxt_rx_out =
        I_RX_MUTE ? mute_level : I_RX_SAMPLE;
    wire logic [SAMPLE_W-1:0] nxt_tx_out =
        I_TX_MUTE ? mute_level : I_TX_SAMPLE;

    // ------------------------------------------------------------------
    // Corner lookup, one per path
    // ------------------------------------------------------------------
    // The receive table is the first eight entries of the send table.
    // Corners are in hundredths of a hertz so the fractional low entries of
    // the send table stay exact.
    logic [1:0][`ECC_CODE_W-1:0] corner_code;
    ecc_corner_t [1:0]           corner_val;

    assign corner_code[0] = `ECC_CODE_W'(receive_hpf_corner);
    assign corner_code[1] = send_hpf_corner;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_corner
            ecc_hpf_corner u_corner (
                .i_code   (corner_code[g]),
                .o_corner (corner_val[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // All eight bits are stored, reserved ones included, so software reads
    // back exactly what it wrote.
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mute_offset_level_ff        <= `ECC_RST_MUTE_OFS;
            highpass_corner_select_ff   <= `ECC_RST_HPF;
            adaptation_step_constant_ff <= `ECC_RST_STEP;
            boot_image_check_ff         <= `ECC_RST_BOOT_CHK;
        end else if (I_CE) begin
            if (wr_mute) begin
                mute_offset_level_ff <= I_REQ.wdata;
            end
            if (wr_hpf) begin
                highpass_corner_select_ff <= I_REQ.wdata;
            end
            if (wr_step) begin
                adaptation_step_constant_ff <= I_REQ.wdata;
            end
            if (wr_boot) begin
                boot_image_check_ff <= I_REQ.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Detector flags
    // ------------------------------------------------------------------
    // Flags follow the detectors; writes to the status offset are ignored.
    // The flags are live copies, not sticky, so there is no software clear
    // and no race between a new detection and a clear.
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            narrowband_receive_flag_ff <= 1'b0;
            narrowband_send_flag_ff    <= 1'b0;
            false_howling_flag_ff      <= 1'b0;
        end else if (I_CE) begin
            narrowband_receive_flag_ff <= I_DET.nb_rx;
            narrowband_send_flag_ff    <= I_DET.nb_tx;
            false_howling_flag_ff      <= I_DET.false_howl;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // A read in the same cycle as a write to that offset returns the value
    // stored before the write. Read data holds until the next read, so
    // software may pick it up some cycles after the valid pulse.
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RDATA  <= `ECC_RDATA_IDLE;
            O_RVALID <= 1'b0;
        end else if (I_CE) begin
            O_RVALID <= I_REQ.rd;
            if (I_REQ.rd) begin
                O_RDATA <= nxt_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sample paths and control outputs
    // ------------------------------------------------------------------
    // Outputs keep their reset values until the first enabled edge after
    // reset, so downstream logic sees zero controls until that edge.
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RX_OUT    <= '0;
            O_TX_OUT    <= '0;
            O_RX_CORNER <= '0;
            O_TX_CORNER <= '0;
            O_STEP_SIZE <= '0;
            O_NB_ANY    <= 1'b0;
        end else if (I_CE) begin
            O_RX_OUT    <= nxt_rx_out;
            O_TX_OUT    <= nxt_tx_out;
            O_RX_CORNER <= corner_val[0];
            O_TX_CORNER <= corner_val[1];
            O_STEP_SIZE <= adaptation_step_size;
            O_NB_ANY    <= narrowband_any_flag;
        end
    end

endmodule // ecc_regs

`default_nettype wire
